// *** core/l2_fault_pkg.sv ***
/*
 Shared constants and carrier types for the level-2 protection fault
 capture block: register byte addresses, field positions, reset values.
 Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
*/
package l2_fault_pkg;
    // Register byte addresses
    localparam logic [31:0] FAULT_ADDR_OFS = 32'h0184a000;
    localparam logic [31:0] FAULT_STAT_OFS = 32'h0184a004;
    localparam logic [31:0] FAULT_CLR_OFS = 32'h0184a008;
    localparam logic [31:0] KEY_WORD_0_OFS = 32'h0184a100;
    localparam logic [31:0] KEY_WORD_1_OFS = 32'h0184a104;
    localparam logic [31:0] KEY_WORD_2_OFS = 32'h0184a108;
    localparam logic [31:0] KEY_WORD_3_OFS = 32'h0184a10c;
    localparam logic [31:0] LOCK_CMD_OFS = 32'h0184a110;
    localparam logic [31:0] LOCK_STATE_OFS = 32'h0184a114;
    localparam logic [31:0] IRQ_STATUS_OFS = 32'h0184a200;
    localparam logic [31:0] IRQ_ENABLE_OFS = 32'h0184a204;
    localparam logic [31:0] IRQ_CLEAR_OFS = 32'h0184a208;
    // Fault status fields
    localparam int STAT_ID_LSB = 9;
    localparam int STAT_ID_W = 7;
    localparam int STAT_LOCAL_BIT = 8;
    localparam int STAT_PRIV_RD_BIT = 5;
    localparam int STAT_PRIV_WR_BIT = 4;
    localparam int STAT_USER_RD_BIT = 2;
    localparam int STAT_USER_WR_BIT = 1;
    localparam logic [31:0] STAT_USED_MASK = 32'h0000ff36;
    // Command and status bits
    localparam int CLR_CMD_BIT = 0;
    localparam int LOCK_ENG_BIT = 0;
    localparam int CMD_UNLOCK_BIT = 0;
    localparam int CMD_LOCK_BIT = 1;
    localparam int CMD_KEY_CLR_BIT = 2;
    localparam int KEY_WORDS = 2;
    localparam int KEY_BITS = 64;
    // Interrupt event bits
    localparam int IRQ_W = 3;
    localparam int IRQ_CAPTURE_BIT = 0;
    localparam int IRQ_REPLACE_BIT = 1;
    localparam int IRQ_LOCK_BIT = 2;
    // Bus
    localparam int PROT_PRIV_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int REQ_ID_W = 8;
    // Reset values
    localparam logic [31:0] WORD_RST = 32'h00000000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
    localparam logic [KEY_BITS-1:0] KEY_RST = 64'h0;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [REQ_ID_W-1:0] id;
        logic local_cpu;
        logic priv;
        logic write;
    } fault_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] status;
    } fault_rec_t;
endpackage

// *** core/fault_record.sv ***
/*
 Single-entry fault record: captures the first fault, lets a CPU-local
 fault replace a remote one, clears on command.
 Assumes fault reports are synchronous to clk_i, one per cycle at most.
*/
`timescale 1ns/1ps
module fault_record
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Fault report and clear command
    input wire l2_fault_pkg::fault_req_t fault_i,
    input wire logic clear_i,
    // Held record and events
    output l2_fault_pkg::fault_rec_t rec_o,
    output logic held_o,
    output logic captured_o,
    output logic replaced_o
);
    import l2_fault_pkg::*;

    logic replace;
    logic take_new;
    logic [31:0] status_next;

    // Local fault may displace a remote record
    assign replace = held_o && !rec_o.status[STAT_LOCAL_BIT]
                     && fault_i.valid && fault_i.local_cpu; // [R10]
    // A new fault in the clearing cycle is kept, not lost
    assign take_new = fault_i.valid && (!held_o || clear_i || replace); // [R9]

    always_comb begin
        status_next = WORD_RST;
        status_next[STAT_LOCAL_BIT] = fault_i.local_cpu; // [R5]
        if (!fault_i.local_cpu) begin
            status_next[STAT_ID_LSB +: STAT_ID_W] = fault_i.id[STAT_ID_W-1:0]; // [R4]
        end
        status_next[STAT_PRIV_RD_BIT] = fault_i.priv && !fault_i.write; // [R6]
        status_next[STAT_PRIV_WR_BIT] = fault_i.priv && fault_i.write; // [R6]
        status_next[STAT_USER_RD_BIT] = !fault_i.priv && !fault_i.write; // [R7]
        status_next[STAT_USER_WR_BIT] = !fault_i.priv && fault_i.write; // [R7]
    end

    // One record only, no queue
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rec_o <= '0;
            held_o <= 1'b0;
        end else if (take_new) begin
            rec_o.addr <= fault_i.addr; // [R3] [R8]
            rec_o.status <= status_next;
            held_o <= 1'b1;
        end else if (clear_i) begin
            rec_o <= '0; // [R11]
            held_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            captured_o <= 1'b0;
            replaced_o <= 1'b0;
        end else begin
            captured_o <= take_new; // [R16]
            replaced_o <= take_new && replace && !clear_i;
        end
    end
endmodule // fault_record

// *** core/l2_protection_fault_capture.sv ***
/*
 Level-2 protection fault capture with lock status, AXI4-Lite slave
 registers, sticky interrupt status and an exception pulse.
 Assumes the permission checker reports faults on FAULT_I in this clock
 domain; AWPROT[0] marks a supervisor access.
*/
// Register access over AXI4-Lite is this design's own decision.
// Function
// R1 - Lock state bit 0 shows engaged, rest zero
// R2 - Only 64-bit key kept; words 2,3 dropped
// R3 - Fault address and status registers are read-only
// R4 - Status bits 15:9 hold low ID bits
// R5 - Local bit set forces ID field zero
// R6 - Bit 5 supervisor read, bit 4 write
// R7 - Bit 2 user read, bit 1 user write
// R8 - Only one fault record held
// R9 - First fault kept, later ones ignored
// R10 - Local fault replaces remote record, new exception
// R11 - Writing clear bit 1 wipes the record
// R12 - Writing clear bit 0 does nothing
// R13 - Clear register bits 31:1 ignored
// R14 - Key words write-only; lock needs command sequence
// R15 - Anyone reads; only supervisor writes clear
// R16 - One-cycle exception pulse on capture or replace
`timescale 1ns/1ps
module l2_protection_fault_capture
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // Fault reports from the permission checker
    input wire l2_fault_pkg::fault_req_t FAULT_I,
    // AXI4-Lite write address and data
    input wire logic AXI_AWVALID_I,
    output logic AXI_AWREADY_O,
    input wire logic [31:0] AXI_AWADDR_I,
    input wire logic [2:0] AXI_AWPROT_I,
    input wire logic AXI_WVALID_I,
    output logic AXI_WREADY_O,
    input wire logic [31:0] AXI_WDATA_I,
    input wire logic [3:0] AXI_WSTRB_I,
    // AXI4-Lite write response
    output logic AXI_BVALID_O,
    input wire logic AXI_BREADY_I,
    output logic [1:0] AXI_BRESP_O,
    // AXI4-Lite read
    input wire logic AXI_ARVALID_I,
    output logic AXI_ARREADY_O,
    input wire logic [31:0] AXI_ARADDR_I,
    input wire logic [2:0] AXI_ARPROT_I,
    output logic AXI_RVALID_O,
    input wire logic AXI_RREADY_I,
    output logic [31:0] AXI_RDATA_O,
    output logic [1:0] AXI_RRESP_O,
    // Events
    output logic EXCEPTION_O,
    output logic IRQ_O,
    output logic LOCK_ENGAGED_O
);
    import l2_fault_pkg::*;

    logic aw_hs, w_hs, ar_hs, b_hs, r_hs, do_write;
    logic aw_held_reg, w_held_reg, wr_priv_reg;
    logic [31:0] wr_addr_reg, wr_data_reg;
    logic [3:0] wr_strb_reg;
    logic wr_known, wr_allowed;
    logic sel_clr, sel_cmd, sel_irq_en, sel_irq_clr;
    logic [KEY_WORDS-1:0] sel_key;
    logic clear_cmd, lock_go, unlock_go, key_reset;
    logic [31:0] key_wr_reg [KEY_WORDS];
    logic [KEY_BITS-1:0] lock_key_reg;
    logic lock_engaged_reg;
    logic [IRQ_W-1:0] irq_status_reg, irq_enable_reg, irq_set, irq_clr;
    fault_rec_t rec;
    logic held, captured, replaced;
    logic [33:0] rd_word;

    assign aw_hs = AXI_AWVALID_I && AXI_AWREADY_O;
    assign w_hs = AXI_WVALID_I && AXI_WREADY_O;
    assign ar_hs = AXI_ARVALID_I && AXI_ARREADY_O;
    assign b_hs = AXI_BVALID_O && AXI_BREADY_I;
    assign r_hs = AXI_RVALID_O && AXI_RREADY_I;
    assign do_write = aw_held_reg && w_held_reg;

    // Address and data taken in either order; ready drops until B done
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            AXI_AWREADY_O <= 1'b1;
            aw_held_reg <= 1'b0;
            wr_addr_reg <= WORD_RST;
            wr_priv_reg <= 1'b0;
        end else begin
            if (aw_hs) begin
                AXI_AWREADY_O <= 1'b0;
                aw_held_reg <= 1'b1;
                wr_addr_reg <= AXI_AWADDR_I;
                wr_priv_reg <= AXI_AWPROT_I[PROT_PRIV_BIT];
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (b_hs) begin
                AXI_AWREADY_O <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            AXI_WREADY_O <= 1'b1;
            w_held_reg <= 1'b0;
            wr_data_reg <= WORD_RST;
            wr_strb_reg <= 4'h0;
        end else begin
            if (w_hs) begin
                AXI_WREADY_O <= 1'b0;
                w_held_reg <= 1'b1;
                wr_data_reg <= AXI_WDATA_I;
                wr_strb_reg <= AXI_WSTRB_I;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
            if (b_hs) begin
                AXI_WREADY_O <= 1'b1;
            end
        end
    end

    always_comb begin
        case (wr_addr_reg)
            FAULT_CLR_OFS, KEY_WORD_0_OFS, KEY_WORD_1_OFS, KEY_WORD_2_OFS,
            KEY_WORD_3_OFS, LOCK_CMD_OFS, IRQ_ENABLE_OFS, IRQ_CLEAR_OFS:
                wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end

    // User-mode writes refused with SLVERR
    assign wr_allowed = wr_known && wr_priv_reg; // [R15]

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            AXI_BVALID_O <= 1'b0;
            AXI_BRESP_O <= RESP_OKAY;
        end else if (do_write) begin
            AXI_BVALID_O <= 1'b1;
            AXI_BRESP_O <= wr_allowed ? RESP_OKAY : RESP_SLVERR;
        end else if (b_hs) begin
            AXI_BVALID_O <= 1'b0;
        end
    end

    assign sel_clr = do_write && wr_allowed && wr_addr_reg == FAULT_CLR_OFS;
    assign sel_cmd = do_write && wr_allowed && wr_addr_reg == LOCK_CMD_OFS
                     && wr_strb_reg[0];
    assign sel_irq_en = do_write && wr_allowed && wr_addr_reg == IRQ_ENABLE_OFS
                        && wr_strb_reg[0];
    assign sel_irq_clr = do_write && wr_allowed && wr_addr_reg == IRQ_CLEAR_OFS
                         && wr_strb_reg[0];
    assign sel_key[0] = do_write && wr_allowed && wr_addr_reg == KEY_WORD_0_OFS;
    assign sel_key[1] = do_write && wr_allowed && wr_addr_reg == KEY_WORD_1_OFS;

    // Only bit 0 acts; a zero there is a no-op
    assign clear_cmd = sel_clr && wr_strb_reg[0] && wr_data_reg[CLR_CMD_BIT]; // [R11] [R12] [R13]

    fault_record u_record (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .fault_i(FAULT_I),
        .clear_i(clear_cmd),
        .rec_o(rec),
        .held_o(held),
        .captured_o(captured),
        .replaced_o(replaced)
    );

    assign EXCEPTION_O = captured; // [R16]

    // Key words 2 and 3 decode but store nothing
    genvar kw, lane;
    generate
        for (kw = 0; kw < KEY_WORDS; kw++) begin : g_key
            for (lane = 0; lane < 4; lane++) begin : g_lane
                always_ff @(posedge CLK_I or negedge ARST_N_I) begin
                    if (!ARST_N_I) begin
                        key_wr_reg[kw][lane*8 +: 8] <= 8'h00;
                    end else if (key_reset) begin
                        key_wr_reg[kw][lane*8 +: 8] <= 8'h00;
                    end else if (sel_key[kw] && wr_strb_reg[lane]) begin
                        key_wr_reg[kw][lane*8 +: 8] <= wr_data_reg[lane*8 +: 8]; // [R2]
                    end
                end
            end
        end
    endgenerate

    // Lock takes the staged key; unlock needs the same key staged again
    assign key_reset = sel_cmd && wr_data_reg[CMD_KEY_CLR_BIT];
    assign lock_go = sel_cmd && wr_data_reg[CMD_LOCK_BIT] && !lock_engaged_reg; // [R14]
    assign unlock_go = sel_cmd && wr_data_reg[CMD_UNLOCK_BIT] && lock_engaged_reg
                       && {key_wr_reg[1], key_wr_reg[0]} == lock_key_reg; // [R14]

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lock_engaged_reg <= 1'b0;
            lock_key_reg <= KEY_RST;
        end else if (lock_go) begin
            lock_engaged_reg <= 1'b1;
            lock_key_reg <= {key_wr_reg[1], key_wr_reg[0]};
        end else if (unlock_go) begin
            lock_engaged_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            LOCK_ENGAGED_O <= 1'b0;
        end else begin
            LOCK_ENGAGED_O <= lock_engaged_reg;
        end
    end

    always_comb begin
        irq_set = IRQ_RST;
        irq_set[IRQ_CAPTURE_BIT] = captured;
        irq_set[IRQ_REPLACE_BIT] = replaced;
        irq_set[IRQ_LOCK_BIT] = lock_go || unlock_go;
        irq_clr = sel_irq_clr ? wr_data_reg[IRQ_W-1:0] : IRQ_RST;
    end

    // Set beats clear in the same cycle
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            irq_status_reg <= IRQ_RST;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            irq_enable_reg <= IRQ_RST;
        end else if (sel_irq_en) begin
            irq_enable_reg <= wr_data_reg[IRQ_W-1:0];
        end
    end

    // One cycle behind the status bit, to keep the pin registered
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // Reads are open to every requestor; write-only words read zero
    always_comb begin
        rd_word = {RESP_OKAY, WORD_RST};
        case (AXI_ARADDR_I)
            FAULT_ADDR_OFS: rd_word[31:0] = rec.addr; // [R3] [R15]
            FAULT_STAT_OFS: rd_word[31:0] = rec.status & STAT_USED_MASK; // [R3]
            LOCK_STATE_OFS: rd_word[LOCK_ENG_BIT] = lock_engaged_reg; // [R1]
            IRQ_STATUS_OFS: rd_word[IRQ_W-1:0] = irq_status_reg;
            IRQ_ENABLE_OFS: rd_word[IRQ_W-1:0] = irq_enable_reg;
            FAULT_CLR_OFS, KEY_WORD_0_OFS, KEY_WORD_1_OFS, KEY_WORD_2_OFS,
            KEY_WORD_3_OFS, LOCK_CMD_OFS, IRQ_CLEAR_OFS:
                rd_word[31:0] = WORD_RST; // [R14]
            default: rd_word[33:32] = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            AXI_ARREADY_O <= 1'b1;
            AXI_RVALID_O <= 1'b0;
            AXI_RDATA_O <= WORD_RST;
            AXI_RRESP_O <= RESP_OKAY;
        end else if (ar_hs) begin
            AXI_ARREADY_O <= 1'b0;
            AXI_RVALID_O <= 1'b1;
            AXI_RDATA_O <= rd_word[31:0];
            AXI_RRESP_O <= rd_word[33:32];
        end else if (r_hs) begin
            AXI_ARREADY_O <= 1'b1;
            AXI_RVALID_O <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    sequence clear_write_s;
        sel_clr && wr_strb_reg[0];
    endsequence

    sequence remote_held_s;
        held && !rec.status[STAT_LOCAL_BIT];
    endsequence

    sequence local_fault_s;
        FAULT_I.valid && FAULT_I.local_cpu;
    endsequence

    lock_state_read_a: assert property ( // [R1]
        ar_hs && AXI_ARADDR_I == LOCK_STATE_OFS
        |=> AXI_RDATA_O == {31'h0, $past(lock_engaged_reg)})
        else $error("lock state read wrong");

    key_word_drop_a: assert property ( // [R2]
        do_write && (wr_addr_reg == KEY_WORD_2_OFS || wr_addr_reg == KEY_WORD_3_OFS)
        |=> $stable(key_wr_reg[0]) && $stable(key_wr_reg[1]))
        else $error("upper key word stored");

    first_capture_a: assert property ( // [R3]
        FAULT_I.valid && !held
        |=> rec.addr == $past(FAULT_I.addr) && held && EXCEPTION_O)
        else $error("first fault not captured");

    local_id_zero_a: assert property ( // [R5]
        rec.status[STAT_LOCAL_BIT] |-> rec.status[STAT_ID_LSB +: STAT_ID_W] == 7'h00)
        else $error("id not zero on local fault");

    id_field_a: assert property ( // [R4]
        FAULT_I.valid && !held && !FAULT_I.local_cpu
        |=> rec.status[STAT_ID_LSB +: STAT_ID_W] == $past(FAULT_I.id[STAT_ID_W-1:0]))
        else $error("id field wrong");

    reserved_zero_a: assert property ( // [R6]
        (rec.status & ~STAT_USED_MASK) == 32'h0 && $onehot0(rec.status[5:0]))
        else $error("reserved status bits set");

    hold_first_a: assert property ( // [R9]
        held && FAULT_I.valid && !clear_cmd && !(!rec.status[STAT_LOCAL_BIT]
        && FAULT_I.local_cpu) |=> $stable(rec) && !EXCEPTION_O)
        else $error("later fault overwrote record");

    local_replace_a: assert property ( // [R10]
        remote_held_s ##0 local_fault_s
        |=> rec.status[STAT_LOCAL_BIT] && EXCEPTION_O ##1 !EXCEPTION_O || $past(FAULT_I.valid))
        else $error("local fault did not replace");

    clear_effect_a: assert property ( // [R11]
        clear_write_s ##0 wr_data_reg[CLR_CMD_BIT] && !FAULT_I.valid
        |=> rec == '0 && !held)
        else $error("clear did not wipe record");

    clear_zero_a: assert property ( // [R12]
        clear_write_s ##0 !wr_data_reg[CLR_CMD_BIT] && !FAULT_I.valid |=> $stable(rec))
        else $error("zero clear changed record");

    user_clear_a: assert property ( // [R15]
        do_write && !wr_priv_reg && !FAULT_I.valid
        |=> AXI_BRESP_O == RESP_SLVERR && $stable(rec))
        else $error("user write not refused");

    exc_pulse_a: assert property ( // [R16]
        EXCEPTION_O && !$past(FAULT_I.valid) |-> 1'b0)
        else $error("exception without fault");
endmodule // l2_protection_fault_capture

// *** dv/fault_source.sv ***
/*
 Model of the permission checker that reports protection faults.
 Assumes callers enter send just after a rising edge of clk_i.
*/
`timescale 1ns/1ps
module fault_source
    import l2_fault_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Fault report toward the block
    output fault_req_t fault_o
);
    initial fault_o = '0;

    // Keep set holds the report up so a second one follows back to back
    task automatic send(input logic [31:0] a, input logic [7:0] rid, input logic [2:0] lpw,
                        input logic keep);
        fault_o <= '{valid:1'b1, addr:a, id:rid, local_cpu:lpw[2], priv:lpw[1], write:lpw[0]};
        @(posedge clk_i);
        // Idle payload is scrambled so nothing can lean on stale fields
        if (!keep) begin
            fault_o <= '{valid:1'b0, addr:~a, id:~rid, local_cpu:~lpw[2], priv:~lpw[1],
                         write:~lpw[0]};
        end
    endtask
endmodule // fault_source

// *** dv/tb_l2_protection_fault_capture.sv ***
/*
 Self-checking bench for the level-2 protection fault capture block.
 Assumes the package, the design and the fault source model compile first.
*/
`timescale 1ns/1ps
module tb_l2_protection_fault_capture;
    import l2_fault_pkg::*;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    fault_req_t fault;
    logic aw_valid = 1'b0;
    logic [31:0] aw_addr = 32'h0;
    logic [2:0] aw_prot = 3'h0;
    logic w_valid = 1'b0;
    logic [31:0] w_data = 32'h0;
    logic [3:0] w_strb = 4'hf;
    logic b_ready = 1'b0;
    logic ar_valid = 1'b0;
    logic [31:0] ar_addr = 32'h0;
    logic [2:0] ar_prot = 3'h0;
    logic r_ready = 1'b0;
    wire logic aw_ready, w_ready, b_valid, ar_ready, r_valid, exc, irq, lock_eng;
    wire logic [1:0] b_resp, r_resp;
    wire logic [31:0] r_data;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [33:0] exp_rd[$];
    logic [1:0] exp_b[$];
    logic exp_exc[$];
    logic fv_d = 1'b0;
    logic [31:0] a;
    logic [7:0] id;
    logic [63:0] key;

    l2_protection_fault_capture u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .FAULT_I(fault),
        .AXI_AWVALID_I(aw_valid), .AXI_AWREADY_O(aw_ready), .AXI_AWADDR_I(aw_addr),
        .AXI_AWPROT_I(aw_prot), .AXI_WVALID_I(w_valid), .AXI_WREADY_O(w_ready),
        .AXI_WDATA_I(w_data), .AXI_WSTRB_I(w_strb), .AXI_BVALID_O(b_valid),
        .AXI_BREADY_I(b_ready), .AXI_BRESP_O(b_resp), .AXI_ARVALID_I(ar_valid),
        .AXI_ARREADY_O(ar_ready), .AXI_ARADDR_I(ar_addr), .AXI_ARPROT_I(ar_prot),
        .AXI_RVALID_O(r_valid), .AXI_RREADY_I(r_ready), .AXI_RDATA_O(r_data),
        .AXI_RRESP_O(r_resp), .EXCEPTION_O(exc), .IRQ_O(irq), .LOCK_ENGAGED_O(lock_eng));

    fault_source u_src (.clk_i(clk), .fault_o(fault));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic cmp_bit(input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Monitor: results are matched against the oldest note in their queue
    always @(posedge clk) begin
        logic [33:0] e;
        if (r_valid === 1'b1 && r_ready) begin
            e = exp_rd.size() ? exp_rd.pop_front() : ~{r_resp, r_data};
            cmp_word(e[31:0], r_data);
            cmp_resp(e[33:32], r_resp);
        end
        if (b_valid === 1'b1 && b_ready)
            cmp_resp(exp_b.size() ? exp_b.pop_front() : ~b_resp, b_resp);
        // Exception may only follow the edge that took a fault
        if (fv_d)
            cmp_bit(exp_exc.size() ? exp_exc.pop_front() : 1'b0, exc);
        else
            cmp_bit(1'b0, exc);
        fv_d = fault.valid;
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic bus_wr(input logic [31:0] ad, input logic [31:0] d, input logic [2:0] p,
                          input logic [1:0] r);
        @(posedge clk);
        exp_b.push_back(r);
        aw_valid <= 1'b1;
        aw_addr <= ad;
        aw_prot <= p;
        w_valid <= 1'b1;
        w_data <= d;
        b_ready <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_ready)
                aw_valid <= 1'b0;
            if (w_ready)
                w_valid <= 1'b0;
        end while (b_valid !== 1'b1);
        b_ready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [31:0] ad, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        exp_rd.push_back({r, d});
        ar_valid <= 1'b1;
        ar_addr <= ad;
        ar_prot <= 3'($urandom);
        r_ready <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_ready)
                ar_valid <= 1'b0;
        end while (r_valid !== 1'b1);
        r_ready <= 1'b0;
    endtask

    // Enter just after a rising edge; keep chains a second report
    task automatic flt(input logic [31:0] fa, input logic [2:0] lpw, input logic e,
                       input logic keep);
        exp_exc.push_back(e);
        u_src.send(fa, id, lpw, keep);
    endtask

    task automatic settle_bit(input logic e, input logic g_sel);
        repeat (2) @(posedge clk);
        #1;
        cmp_bit(e, g_sel ? lock_eng : irq);
    endtask

    function automatic logic [31:0] stat(input logic [7:0] rid, input logic [2:0] lpw);
        logic [31:0] s;
        s = 32'h0;
        if (lpw[2])
            s[8] = 1'b1;
        else
            s[15:9] = rid[6:0];
        s[lpw[1] ? (lpw[0] ? 4 : 5) : (lpw[0] ? 1 : 2)] = 1'b1;
        return s;
    endfunction

    initial begin
        void'($urandom(19250));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        bus_rd(FAULT_ADDR_OFS, 32'h0, RESP_OKAY);
        bus_rd(LOCK_STATE_OFS, 32'h0, RESP_OKAY);
        bus_wr(FAULT_ADDR_OFS, 32'h1, 3'h1, RESP_SLVERR);
        bus_wr(FAULT_STAT_OFS, 32'h1, 3'h1, RESP_SLVERR);
        bus_wr(32'h0184a0f0, 32'h1, 3'h1, RESP_SLVERR);
        // Every access type, each captured then wiped
        for (int k = 0; k < 4; k++) begin
            a = $urandom;
            id = 8'($urandom);
            @(posedge clk);
            flt(a, {1'b0, k[1:0]}, 1'b1, 1'b0);
            bus_rd(FAULT_ADDR_OFS, a, RESP_OKAY);
            bus_rd(FAULT_STAT_OFS, stat(id, {1'b0, k[1:0]}), RESP_OKAY);
            bus_wr(FAULT_CLR_OFS, 32'h1, 3'h1, RESP_OKAY);
            bus_rd(FAULT_STAT_OFS, 32'h0, RESP_OKAY);
        end
        bus_rd(FAULT_ADDR_OFS, 32'h0, RESP_OKAY);
        // Remote record blocks a remote fault, yields to a local one
        id = 8'($urandom) | 8'h41;
        @(posedge clk);
        flt(a, 3'b000, 1'b1, 1'b1);
        flt(~a, 3'b001, 1'b0, 1'b0);
        bus_rd(FAULT_ADDR_OFS, a, RESP_OKAY);
        @(posedge clk);
        flt(a ^ 32'h10, 3'b110, 1'b1, 1'b1);
        flt(a, 3'b101, 1'b0, 1'b0);
        bus_rd(FAULT_ADDR_OFS, a ^ 32'h10, RESP_OKAY);
        bus_rd(FAULT_STAT_OFS, stat(id, 3'b110), RESP_OKAY);
        bus_wr(FAULT_CLR_OFS, 32'h0, 3'h1, RESP_OKAY);
        bus_wr(FAULT_CLR_OFS, 32'hfffffffe, 3'h1, RESP_OKAY);
        bus_wr(FAULT_CLR_OFS, 32'h1, 3'h0, RESP_SLVERR);
        bus_rd(FAULT_STAT_OFS, stat(id, 3'b110), RESP_OKAY);
        bus_rd(FAULT_ADDR_OFS, a ^ 32'h10, RESP_OKAY);
        bus_wr(FAULT_CLR_OFS, 32'hffffffff, 3'h1, RESP_OKAY);
        bus_rd(FAULT_STAT_OFS, 32'h0, RESP_OKAY);
        // Interrupt: raised, masked, cleared
        bus_rd(IRQ_STATUS_OFS, 32'h3, RESP_OKAY);
        bus_wr(IRQ_ENABLE_OFS, 32'h2, 3'h1, RESP_OKAY);
        settle_bit(1'b1, 1'b0);
        bus_wr(IRQ_ENABLE_OFS, 32'h0, 3'h1, RESP_OKAY);
        settle_bit(1'b0, 1'b0);
        bus_wr(IRQ_ENABLE_OFS, 32'h1, 3'h1, RESP_OKAY);
        bus_wr(IRQ_CLEAR_OFS, 32'h7, 3'h1, RESP_OKAY);
        settle_bit(1'b0, 1'b0);
        bus_rd(IRQ_STATUS_OFS, 32'h0, RESP_OKAY);
        // Lock, refused unlock, then unlock with ignored upper key words
        key = {$urandom, $urandom};
        bus_wr(KEY_WORD_0_OFS, key[31:0], 3'h1, RESP_OKAY);
        bus_wr(KEY_WORD_1_OFS, key[63:32], 3'h1, RESP_OKAY);
        bus_rd(KEY_WORD_1_OFS, 32'h0, RESP_OKAY);
        bus_wr(LOCK_CMD_OFS, 32'h2, 3'h1, RESP_OKAY);
        bus_rd(LOCK_STATE_OFS, 32'h1, RESP_OKAY);
        settle_bit(1'b1, 1'b1);
        bus_wr(LOCK_CMD_OFS, 32'h4, 3'h1, RESP_OKAY);
        bus_wr(LOCK_CMD_OFS, 32'h1, 3'h1, RESP_OKAY);
        bus_rd(LOCK_STATE_OFS, 32'h1, RESP_OKAY);
        for (int k = 0; k < 4; k++)
            bus_wr(KEY_WORD_0_OFS + 32'(4 * k), k < 2 ? key[32 * k +: 32] : $urandom, 3'h1,
                   RESP_OKAY);
        bus_wr(LOCK_CMD_OFS, 32'h1, 3'h1, RESP_OKAY);
        bus_rd(LOCK_STATE_OFS, 32'h0, RESP_OKAY);
        settle_bit(1'b0, 1'b1);
        // Lock and unlock both raise the lock event bit
        bus_rd(IRQ_STATUS_OFS, 32'h4, RESP_OKAY);
        repeat (3) @(posedge clk);
        cmp_word(32'h0, 32'(exp_rd.size() + exp_b.size() + exp_exc.size()));
        stop_test();
    end
endmodule // tb_l2_protection_fault_capture
